// File: fmc_pkg.sv
// Constants shared by the FM transmitter command slice
package fmc_pkg;
  // Opcodes and power-up functions
  localparam logic [7:0] OP_POWER_UP   = 8'h01;
  localparam logic [7:0] OP_REV_QUERY  = 8'h10;
  localparam logic [7:0] OP_POWER_DOWN = 8'h11;
  localparam logic [7:0] OP_SET_CFG    = 8'h12;
  localparam logic [3:0] FN_TRANSMIT   = 4'h2;
  localparam logic [3:0] FN_LIB_QUERY  = 4'hF;
  localparam logic [7:0] OPMODE_DIGITAL = 8'h0F;
  // Argument counts and reply lengths
  localparam logic [2:0] NARG_POWER_UP = 3'h2;
  localparam logic [2:0] NARG_SET_CFG  = 3'h5;
  localparam logic [3:0] LEN_LIB_REPLY = 4'h7;
  localparam logic [3:0] LEN_REV_REPLY = 4'h8;
  // Field positions
  localparam int STAT_CTS_BIT  = 7;
  localparam int STAT_ERR_BIT  = 6;
  localparam int ARG_CTSIEN    = 7;
  localparam int ARG_GPO2OEN   = 6;
  localparam int IRQ_CTS_BIT   = 0;
  localparam int IRQ_ERR_BIT   = 1;
  localparam int IRQ_FLAG_BIT  = 2;
  localparam int PIN_TWO_OE    = 1;
  localparam int PIN_THREE_OE  = 2;
  localparam int PIN_TWO_LVL   = 9;
  localparam int PIN_THREE_LVL = 10;
  localparam logic [15:0] PIN_CTL_ID = 16'h0001;
  // Register offsets
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_REPLY    = 8'h04;
  localparam logic [7:0] OFF_STATE    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CFG      = 8'h14;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  // Command execution time
  localparam int CLK_PERIOD_PS = 4000;
  localparam int EXEC_TIME_NS  = 40;
  localparam int EXEC_CYC = (EXEC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// File: fmc_if.sv
// Internal carrier between command front end, collector and reply buffer
`timescale 1ns/1ps
interface fmc_if;
  logic        byte_vld;
  logic [7:0]  byte_dat;
  logic        collecting;
  logic        cmd_vld;
  logic [7:0]  opcode;
  logic [39:0] args;
  logic        rep_load;
  logic [3:0]  rep_len;
  logic [63:0] rep_bytes;
  logic        rep_pop;
  logic [7:0]  rep_dat;
  logic        rep_more;
  modport coll (input byte_vld, byte_dat, output collecting, cmd_vld, opcode, args);
  modport rply (input rep_load, rep_len, rep_bytes, rep_pop, output rep_dat, rep_more);
endinterface

// File: fmc_collect.sv
// Gathers an opcode and its argument bytes into one command
`timescale 1ns/1ps
module fmc_collect (
  input wire logic pclk,
  input wire logic presetn,
  fmc_if.coll      bus
);
  logic [2:0]  left_r;
  logic [2:0]  idx_r;
  logic [7:0]  op_r;
  logic [39:0] args_r;
  logic        done_r;
  logic [2:0]  nargs;

  // Argument count per opcode
  always_comb begin
    case (bus.byte_dat)
      fmc_pkg::OP_POWER_UP: nargs = fmc_pkg::NARG_POWER_UP;
      fmc_pkg::OP_SET_CFG:  nargs = fmc_pkg::NARG_SET_CFG;
      default:              nargs = 3'h0;
    endcase
  end

  // Byte sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 3'h0;
      idx_r  <= 3'h0;
      op_r   <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (bus.byte_vld) begin
        if (left_r == 3'h0) begin
          op_r   <= bus.byte_dat;
          left_r <= nargs;
          idx_r  <= 3'h0;
          done_r <= (nargs == 3'h0);
        end else begin
          left_r <= left_r - 3'h1;
          idx_r  <= idx_r + 3'h1;
          done_r <= (left_r == 3'h1);
        end
      end
    end
  end

  // Argument storage, first argument in the low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      args_r <= 40'h0;
    end else if (bus.byte_vld && left_r != 3'h0) begin
      args_r[8*idx_r +: 8] <= bus.byte_dat;
    end
  end

  assign bus.collecting = (left_r != 3'h0);
  assign bus.cmd_vld    = done_r;
  assign bus.opcode     = op_r;
  assign bus.args       = args_r;
endmodule

// File: fmc_reply.sv
// Holds reply bytes and hands them out one per read
`timescale 1ns/1ps
module fmc_reply #(
  parameter int DEPTH = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  fmc_if.rply      bus
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem_r [DEPTH];
  logic [3:0] len_r;
  logic [3:0] pos_r;

  // Reply storage
  always_ff @(posedge pclk) begin
    if (bus.rep_load) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= bus.rep_bytes[8*i +: 8];
      end
    end
  end

  // Read position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= 4'h0;
      pos_r <= 4'h0;
    end else if (bus.rep_load) begin
      len_r <= bus.rep_len;
      pos_r <= 4'h0;
    end else if (bus.rep_pop && pos_r < len_r) begin
      pos_r <= pos_r + 4'h1;
    end
  end

  assign bus.rep_more = (pos_r < len_r);
  assign bus.rep_dat  = bus.rep_more ? mem_r[pos_r[AW-1:0]] : 8'h00;
endmodule

// File: fmc_top.sv
// FM transmitter command slice: APB front end, power state, replies, status
// Function
// - Transmit power-up replies with the status byte alone.
// - Library query reply: status then seven identification bytes.
// - Revision query has no arguments; status plus eight reply bytes.
// - Revision bytes: part, fw major, fw minor, patch high, low, component, chip.
// - Revision query ends when clear-to-send rises, optional interrupt.
// - Power-down has no arguments, returns status, moves to powered down.
// - Powered down, only power-up is answered; others get no response.
// - Set command has five argument bytes: zero, id high, low, value high, low.
// - After power-down or set, clear-to-send rises; no reply bytes.
// - Interrupt use and audio clock use override pin control property.
// - Status byte: cts, error, three reserved, three interrupt flags.
// - Clear-to-send low means wait; high permits the next command.
// - Library query returns to powered down; function two means transmit.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fmc_top #(
  parameter logic [7:0] PART_SUFFIX_BYTE     = 8'h11, // Arbitrary value
  parameter logic [7:0] FIRMWARE_MAJOR_BYTE  = 8'h01, // Arbitrary value
  parameter logic [7:0] FIRMWARE_MINOR_BYTE  = 8'h02, // Arbitrary value
  parameter logic [7:0] PATCH_ID_HIGH        = 8'h00, // Arbitrary value
  parameter logic [7:0] PATCH_ID_LOW         = 8'h00, // Arbitrary value
  parameter logic [7:0] COMPONENT_MAJOR_BYTE = 8'h03, // Arbitrary value
  parameter logic [7:0] COMPONENT_MINOR_BYTE = 8'h00, // Arbitrary value
  parameter logic [7:0] SILICON_REVISION_BYTE = 8'h41, // Arbitrary value
  parameter logic [7:0] LIBRARY_REVISION_BYTE = 8'h05  // Arbitrary value
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        data_service_irq_flag,
  input  wire logic        signal_quality_irq_flag,
  input  wire logic        seek_tune_done_flag,
  output logic             general_output_two_o,
  output logic             general_output_two_oe,
  output logic             general_output_three_o,
  output logic             general_output_three_oe
);
  typedef enum logic {ST_IDLE, ST_EXEC} fmc_state_e;

  fmc_if u_if ();

  fmc_state_e  state_r;
  logic [7:0]  cnt_r;
  logic        cts_r;
  logic        err_r;
  logic        up_r;
  logic        stat_pend_r;
  logic        ctsien_r;
  logic        gpo2oen_r;
  logic [7:0]  opmode_r;
  logic [15:0] cfg_id_r;
  logic [15:0] cfg_val_r;
  logic [15:0] pin_ctl_r;
  logic [2:0]  flags_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;
  logic        two_o_r;
  logic        two_oe_r;
  logic        three_o_r;
  logic        three_oe_r;

  logic        setup;
  logic        acc;
  logic        wr_cmd;
  logic        rd_reply;
  logic        rd_irq;
  logic        mapped;
  logic        finish;
  logic [7:0]  status_byte;
  logic [7:0]  arg1;
  logic        fin_err;
  logic        fin_up;
  logic        fin_cts_ie;
  logic [2:0]  irq_ev;
  logic [2:0]  irq_stat_nxt;

  // Command collector and reply buffer
  fmc_collect u_collect (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (u_if.coll)
  );

  fmc_reply #(.DEPTH(8)) u_reply (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (u_if.rply)
  );

  // APB phase decode; side effects only at the completing edge
  assign setup    = psel && !penable;
  assign acc      = psel && penable && pready_r;
  assign wr_cmd   = acc && pwrite && paddr == fmc_pkg::OFF_CMD && !pslverr_r;
  assign rd_reply = acc && !pwrite && paddr == fmc_pkg::OFF_REPLY;
  assign rd_irq   = acc && !pwrite && paddr == fmc_pkg::OFF_IRQ_STAT;

  always_comb begin
    case (paddr)
      fmc_pkg::OFF_CMD, fmc_pkg::OFF_REPLY, fmc_pkg::OFF_STATE,
      fmc_pkg::OFF_IRQ_STAT, fmc_pkg::OFF_IRQ_MASK, fmc_pkg::OFF_CFG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Status byte, reserved bits read as zero
  assign status_byte = {cts_r, err_r, 3'b000, flags_r};

  // Command bytes enter only when clear to send; powered down, only power-up starts one
  assign u_if.byte_vld = wr_cmd && cts_r && state_r == ST_IDLE &&
    (up_r || u_if.collecting || pwdata[7:0] == fmc_pkg::OP_POWER_UP);
  assign u_if.byte_dat = pwdata[7:0];
  assign u_if.rep_pop  = rd_reply && !stat_pend_r;

  assign finish = (state_r == ST_EXEC) && (cnt_r == 8'h00);
  assign arg1   = u_if.args[7:0];

  // Outcome of the command in execution
  always_comb begin
    fin_err        = 1'b0;
    fin_up         = up_r;
    fin_cts_ie     = ctsien_r;
    u_if.rep_len   = 4'h0;
    u_if.rep_bytes = 64'h0;
    if (!up_r) begin
      fin_cts_ie = arg1[fmc_pkg::ARG_CTSIEN];
      if (arg1[3:0] == fmc_pkg::FN_TRANSMIT) begin
        fin_up = 1'b1;
      end else if (arg1[3:0] == fmc_pkg::FN_LIB_QUERY) begin
        u_if.rep_len   = fmc_pkg::LEN_LIB_REPLY;
        u_if.rep_bytes = {8'h00, LIBRARY_REVISION_BYTE, SILICON_REVISION_BYTE,
                          8'h00, 8'h00, FIRMWARE_MINOR_BYTE, FIRMWARE_MAJOR_BYTE,
                          PART_SUFFIX_BYTE};
      end else begin
        fin_err = 1'b1;
      end
    end else begin
      case (u_if.opcode)
        fmc_pkg::OP_REV_QUERY: begin
          u_if.rep_len   = fmc_pkg::LEN_REV_REPLY;
          u_if.rep_bytes = {SILICON_REVISION_BYTE, COMPONENT_MINOR_BYTE,
                            COMPONENT_MAJOR_BYTE, PATCH_ID_LOW, PATCH_ID_HIGH,
                            FIRMWARE_MINOR_BYTE, FIRMWARE_MAJOR_BYTE,
                            PART_SUFFIX_BYTE};
        end
        fmc_pkg::OP_POWER_DOWN: fin_up = 1'b0;
        fmc_pkg::OP_SET_CFG:    fin_err = (arg1 != 8'h00);
        default:                fin_err = 1'b1;
      endcase
    end
  end

  assign u_if.rep_load = finish;

  // Execution sequencer: clear-to-send drops for the whole execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      cts_r   <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (u_if.cmd_vld) begin
            state_r <= ST_EXEC;
            cnt_r   <= 8'(fmc_pkg::EXEC_CYC - 1);
            cts_r   <= 1'b0;
          end
        end
        ST_EXEC: begin
          if (finish) begin
            state_r <= ST_IDLE;
            cts_r   <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  // Power state, error flag and power-up options
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r      <= 1'b0;
      err_r     <= 1'b0;
      ctsien_r  <= 1'b0;
      gpo2oen_r <= 1'b0;
      opmode_r  <= 8'h00;
    end else if (finish) begin
      up_r  <= fin_up;
      err_r <= fin_err;
      if (!up_r && fin_up) begin
        ctsien_r  <= arg1[fmc_pkg::ARG_CTSIEN];
        gpo2oen_r <= arg1[fmc_pkg::ARG_GPO2OEN];
        opmode_r  <= u_if.args[15:8];
      end
    end
  end

  // Stored configuration value and pin control property
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_id_r  <= 16'h0000;
      cfg_val_r <= 16'h0000;
      pin_ctl_r <= 16'h0000;
    end else if (finish && up_r && u_if.opcode == fmc_pkg::OP_SET_CFG && !fin_err) begin
      cfg_id_r  <= {u_if.args[15:8], u_if.args[23:16]};
      cfg_val_r <= {u_if.args[31:24], u_if.args[39:32]};
      if ({u_if.args[15:8], u_if.args[23:16]} == fmc_pkg::PIN_CTL_ID) begin
        pin_ctl_r <= {u_if.args[31:24], u_if.args[39:32]};
      end
    end
  end

  // Status byte leads each reply stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_pend_r <= 1'b0;
    end else if (finish) begin
      stat_pend_r <= 1'b1;
    end else if (rd_reply) begin
      stat_pend_r <= 1'b0;
    end
  end

  // Interrupt flags from the receive path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 3'b000;
    end else begin
      flags_r <= {data_service_irq_flag, signal_quality_irq_flag, seek_tune_done_flag};
    end
  end

  // Sticky events; a new event wins over a read-clear of the same bit
  always_comb begin
    irq_ev = 3'b000;
    irq_ev[fmc_pkg::IRQ_CTS_BIT]  = finish && fin_cts_ie;
    irq_ev[fmc_pkg::IRQ_ERR_BIT]  = finish && fin_err;
    irq_ev[fmc_pkg::IRQ_FLAG_BIT] = |({data_service_irq_flag, signal_quality_irq_flag,
                                      seek_tune_done_flag} & ~flags_r);
    irq_stat_nxt = irq_stat_r;
    if (rd_irq) begin
      irq_stat_nxt = irq_stat_r & ~prdata_r[2:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 3'b000;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= fmc_pkg::RST_IRQ_MASK;
    end else if (acc && pwrite && paddr == fmc_pkg::OFF_IRQ_MASK) begin
      irq_mask_r <= pwdata[2:0];
    end
  end

  // APB answer prepared in setup, presented in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          fmc_pkg::OFF_REPLY:    prdata_r <= {24'h0, stat_pend_r ? status_byte : u_if.rep_dat};
          fmc_pkg::OFF_STATE:    prdata_r <= {23'h0, up_r, status_byte};
          fmc_pkg::OFF_IRQ_STAT: prdata_r <= {29'h0, irq_stat_r};
          fmc_pkg::OFF_IRQ_MASK: prdata_r <= {29'h0, irq_mask_r};
          fmc_pkg::OFF_CFG:      prdata_r <= {cfg_id_r, cfg_val_r};
          default:               prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // General outputs: interrupt and audio clock uses override pin control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_o_r    <= 1'b0;
      two_oe_r   <= 1'b0;
      three_o_r  <= 1'b0;
      three_oe_r <= 1'b0;
    end else begin
      if (up_r && gpo2oen_r) begin
        two_oe_r <= 1'b1;
        two_o_r  <= !irq_r;
      end else begin
        two_oe_r <= pin_ctl_r[fmc_pkg::PIN_TWO_OE];
        two_o_r  <= pin_ctl_r[fmc_pkg::PIN_TWO_LVL];
      end
      if (up_r && opmode_r == fmc_pkg::OPMODE_DIGITAL) begin
        three_oe_r <= 1'b0;
        three_o_r  <= 1'b0;
      end else begin
        three_oe_r <= pin_ctl_r[fmc_pkg::PIN_THREE_OE];
        three_o_r  <= pin_ctl_r[fmc_pkg::PIN_THREE_LVL];
      end
    end
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign irq                     = irq_r;
  assign general_output_two_o    = two_o_r;
  assign general_output_two_oe   = two_oe_r;
  assign general_output_three_o  = three_o_r;
  assign general_output_three_oe = three_oe_r;
endmodule

// File: fmc_top_sva.sv
// Port-level checker for the FM transmitter command slice
`timescale 1ns/1ps
module fmc_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        data_service_irq_flag,
  input wire logic        signal_quality_irq_flag,
  input wire logic        seek_tune_done_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] flg;
  logic       acc;
  logic       mapped;
  logic       clr;
  // Completed transfer, address decode and flag group
  assign flg = {data_service_irq_flag, signal_quality_irq_flag, seek_tune_done_flag};
  assign acc = psel && penable && pready;
  assign mapped = (paddr <= fmc_pkg::OFF_CFG) && (paddr[1:0] == 2'h0);
  assign clr = acc && (paddr == fmc_pkg::OFF_IRQ_STAT || paddr == fmc_pkg::OFF_IRQ_MASK);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no access after setup");
  a_ready_in_access: assert property (pready |-> penable && $past(psel && !penable))
    else $error("pready outside access");
  a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
  a_slverr_decode: assert property (acc |-> pslverr == !mapped) else $error("bad pslverr");
  a_cmd_reads_zero: assert property (acc && !pwrite && paddr == fmc_pkg::OFF_CMD |-> prdata == 32'h0)
    else $error("command register read not zero");
  a_prdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_flags_in_status: assert property (acc && !pwrite && paddr == fmc_pkg::OFF_STATE
    && flg == $past(flg) && flg == $past(flg, 2) && flg == $past(flg, 3) |-> prdata[2:0] == flg)
    else $error("flag bits wrong in status");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2))
    else $error("irq fell without clear or mask");
endmodule
bind fmc_top fmc_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .irq, .data_service_irq_flag, .signal_quality_irq_flag,
  .seek_tune_done_flag);

// File: fmc_ctl_model.sv
// System controller model: APB master that sends commands and reads replies
`timescale 1ns/1ps
module fmc_ctl_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends a wait for the answer
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data does not keep its value
  endtask
  // Waits for clear-to-send, then writes opcode and arguments in order
  task automatic send(input logic [63:0] b, input int n);
    logic [31:0] q;
    logic        e;
    q = 32'h0;
    while (q[7] !== 1'b1) xfer(1'b0, fmc_pkg::OFF_STATE, 32'h0, q, e);
    for (int i = 0; i < n; i++) xfer(1'b1, fmc_pkg::OFF_CMD, {24'h0, b[8*i+:8]}, q, e);
  endtask
endmodule

// File: fmc_top_tb.sv
// Self-checking testbench for the FM transmitter command slice
`timescale 1ns/1ps
module fmc_top_tb;
  localparam logic [7:0] IDB [9] = '{8'h3C, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65, 8'h76, 8'h87,
                                     8'h98};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ds, sq, st;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        two_o, two_oe, three_o, three_oe, e;
  int          num_errors, n_compared;
  // Clock: starts low, 4 ns period
  initial begin
    pclk = 1'b0;
  end
  always #2 pclk = ~pclk;
  fmc_top #(.PART_SUFFIX_BYTE(IDB[0]), .FIRMWARE_MAJOR_BYTE(IDB[1]),
    .FIRMWARE_MINOR_BYTE(IDB[2]), .PATCH_ID_HIGH(IDB[3]), .PATCH_ID_LOW(IDB[4]),
    .COMPONENT_MAJOR_BYTE(IDB[5]), .COMPONENT_MINOR_BYTE(IDB[6]),
    .SILICON_REVISION_BYTE(IDB[7]), .LIBRARY_REVISION_BYTE(IDB[8])) u_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .data_service_irq_flag(ds), .signal_quality_irq_flag(sq), .seek_tune_done_flag(st),
    .general_output_two_o(two_o), .general_output_two_oe(two_oe),
    .general_output_three_o(three_o), .general_output_three_oe(three_oe));
  fmc_ctl_model u_ctl (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_ctl.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_cts();
    int n;
    n = 0;
    do begin
      rd(fmc_pkg::OFF_STATE);
      n++;
    end while (q[7] !== 1'b1 && n < 20);
    chk("cts in time", 32'h1, {31'h0, q[7]});
  endtask
  // Reads the reply stream: masked status, listed bytes, then an empty read
  task automatic reply(input int n, input int idx [8], input int skip);
    rd(fmc_pkg::OFF_REPLY);
    chk("reply status", 32'h80, q & 32'hC7);
    for (int i = 0; i < n; i++) begin
      rd(fmc_pkg::OFF_REPLY);
      if (i != skip && i != skip + 1) chk("reply byte", {24'h0, IDB[idx[i]]}, q);
    end
    rd(fmc_pkg::OFF_REPLY);
    chk("reply end", 32'h0, q);
  endtask
  task automatic t_lib();
    u_ctl.send(64'h500F01, 3);
    wait_cts();
    chk("lib stays down", 32'h0, {31'h0, q[8]});
    reply(7, '{0, 1, 2, 0, 0, 7, 8, 0}, 3);
    $display("test lib done");
  endtask
  task automatic t_tx_up();
    u_ctl.send(64'h500201, 3);
    rd(fmc_pkg::OFF_STATE);
    chk("busy cts", 32'h0, {31'h0, q[7]});
    wait_cts();
    chk("powered up", 32'h100, q & 32'h140);
    reply(0, '{0, 0, 0, 0, 0, 0, 0, 0}, 9);
    $display("test power up done");
  endtask
  task automatic t_rev();
    u_ctl.send(64'h10, 1);
    wait_cts();
    reply(8, '{0, 1, 2, 3, 4, 5, 6, 7}, 9);
    $display("test revision done");
  endtask
  task automatic t_set();
    u_ctl.send(64'h060601000012, 6);
    wait_cts();
    rd(fmc_pkg::OFF_CFG);
    chk("cfg", 32'h00010606, q);
    chk("pins", 32'hF, {28'h0, two_oe, two_o, three_oe, three_o});
    reply(0, '{0, 0, 0, 0, 0, 0, 0, 0}, 9);
    u_ctl.send(64'h000001000112, 6);
    wait_cts();
    chk("bad arg err", 32'h1, {31'h0, q[6]});
    $display("test set done");
  endtask
  task automatic t_irq();
    u_ctl.xfer(1'b1, fmc_pkg::OFF_IRQ_MASK, 32'h7, q, e);
    rd(fmc_pkg::OFF_IRQ_STAT);
    @(posedge pclk) {ds, st} <= 2'b11;
    repeat (4) @(posedge pclk);
    chk("irq up", 32'h1, {31'h0, irq});
    rd(fmc_pkg::OFF_STATE);
    chk("flags", 32'h5, {29'h0, q[2:0]});
    rd(fmc_pkg::OFF_CMD);
    chk("cmd reads zero", 32'h0, q);
    rd(fmc_pkg::OFF_IRQ_STAT);
    chk("flag event", 32'h1, {31'h0, q[2]});
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    u_ctl.xfer(1'b1, fmc_pkg::OFF_IRQ_MASK, 32'h0, q, e);
    @(posedge pclk) sq <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    u_ctl.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("test irq done");
  endtask
  task automatic t_down();
    u_ctl.send(64'h11, 1);
    wait_cts();
    chk("powered down", 32'h080, q & 32'h1C0);
    u_ctl.send(64'h10, 1);
    rd(fmc_pkg::OFF_STATE);
    chk("ignored", 32'h080, q & 32'h1C0);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    $display("test power down done");
  endtask
  task automatic t_pins();
    u_ctl.send(64'h0FC201, 3);
    u_ctl.send(64'h060001000012, 6);
    wait_cts();
    chk("pin override", 32'h6, {29'h0, two_oe, two_o, three_oe});
    rd(fmc_pkg::OFF_IRQ_STAT);
    chk("cts event", 32'h1, {31'h0, q[0]});
    $display("test pin override done");
  endtask
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    num_errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    {ds, sq, st} = 3'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_lib();
    t_tx_up();
    t_rev();
    t_set();
    t_irq();
    t_down();
    t_pins();
    end_sim();
  end
  // Watchdog
  initial begin
    #40000;
    num_errors++;
    end_sim();
  end
endmodule
